// [hw/abfp_pkg.sv]
// Purpose: Shared types and constants for the asynchronous byte FIFO host port
// Assumes: One channel per instance; the USB side presents simple byte streams
// Notes:   Mode codes come from the nonvolatile configuration of each channel
package abfp_pkg;
  localparam int unsigned DATA_W      = 8;     // Byte lane width
  localparam logic [1:0]  MODE_OFF    = 2'h0;  // Channel not in FIFO port mode
  localparam logic [1:0]  MODE_FIFO   = 2'h1;  // Asynchronous byte FIFO mode
  localparam logic        STROBE_IDLE = 1'b1;  // Strobe reset level (inactive high)

  // Byte moving between the port and the USB buffers
  typedef struct packed {
    logic              valid;
    logic [DATA_W-1:0] data;
  } abfp_byte_t;

  // Drive side of the bidirectional data bus as two signals
  typedef struct packed {
    logic [DATA_W-1:0] dout;
    logic              oe;
  } abfp_bus_drv_t;

  // Status seen from the USB engine
  typedef struct packed {
    logic suspended;
    logic wake_enabled;
  } abfp_usb_state_t;
endpackage : abfp_pkg

// [hw/abfp_port.sv]
// Purpose: Device-side logic of one asynchronous byte FIFO host port channel
// Assumes: Strobes and data are synchronous to sys_clk; buffers live in the USB engine
// Notes:   Edges of the strobes are found by comparing with the last sampled level
//          A strobe must stay low or high for at least one clock to be seen at all
//          Reads and writes share one data bus; the host keeps the strobes apart
//          Flags are registered, so they lag the buffer state by one clock
//          The bus enable waits until the low read level has been seen twice, which
//          gives the host's drivers a clock to let go of the bus
`timescale 1ns/1ns
`default_nettype none
module abfp_port
  import abfp_pkg::*;
(
  input  wire logic                    sys_clk,            // System clock, 100 MHz
  input  wire logic                    arst_n,             // Async reset, active low
  input  wire logic [1:0]              chan_mode,          // Configured port mode
  input  wire abfp_pkg::abfp_usb_state_t usb_state,        // Suspend and wake enable
  input  wire logic                    rd_strobe_n,        // Host read strobe
  input  wire logic                    wr_strobe_n,        // Host write strobe
  input  wire logic                    send_now_wake_in,   // Send-immediate / wake, low pulse
  input  wire logic [7:0]              data_bus_in,        // Data bus pin input
  output logic      [7:0]              data_bus_out,       // Data bus pin output
  output logic                         data_bus_oe,        // Data bus drive enable
  output logic                         rx_data_avail_n,    // Receive flag level
  output logic                         rx_data_avail_oe,   // Receive flag drive enable
  output logic                         tx_room_avail_n,    // Transmit flag level
  output logic                         tx_room_avail_oe,   // Transmit flag drive enable
  input  wire abfp_pkg::abfp_byte_t    rx_head,            // Head of receive buffer
  output logic                         rx_pop,             // Advance receive buffer
  output abfp_pkg::abfp_byte_t         tx_push,            // Byte into transmit buffer
  input  wire logic                    tx_room,            // Transmit buffer has room
  output logic                         send_now,           // Flush pending transmit data
  output logic                         wake_req            // Request resume on the bus
);
  import abfp_pkg::*;

  // Read walk, edge by edge:
  //   c0    read strobe sampled low after high: head byte latched, bus driven
  //   cN    read strobe sampled high again: bus released at once,
  //         advance pulse and forced-high receive flag from this edge
  //   cN+1  advance pulse ends; flag still held while the new head settles
  //   cN+2  flag follows the valid bit of the new head byte
  //
  // Write walk:
  //   c0    write strobe sampled low after high with room: byte captured
  //   c0+1  push pulse has ended; one clock wide only
  //
  // Wake walk:
  //   c0    wake input sampled low after high: resume request when suspended
  //         with wake enabled, flush pulse when not suspended
  //
  // Limitations:
  //   A write with no room is dropped without any signal to the host; the
  //   transmit flag is the only guard, so the host must honour it.
  //   A read with the receive flag high returns a stale head byte and still
  //   advances the buffer; the USB engine must ignore an advance when empty.
  //   Both strobes low together is not checked here; the host owns that rule.
  //   Strobes are taken as synchronous; a host on another clock needs an
  //   outside synchroniser, which costs two clocks of latency per edge.

  // Sampled levels for edge detection and state
  logic        rd_q, rd_d;          // Last read strobe level
  logic        wr_q, wr_d;          // Last write strobe level
  logic        wake_in_q, wake_in_d; // Last wake input level
  logic        out_en_q, out_en_d;  // Flags driven once reset is released
  logic [7:0]  dout_q, dout_d;      // Byte held on the bus
  logic        rx_flag_q, rx_flag_d; // Receive flag register
  logic        tx_flag_q, tx_flag_d; // Transmit flag register
  abfp_byte_t  push_q, push_d;      // Captured write byte pulse
  logic        pop_q, pop_d;        // Receive advance pulse
  logic        now_q, now_d;        // Flush pulse
  logic        wake_q, wake_d;      // Resume pulse
  logic        enabled;             // Channel is in FIFO port mode

  // Edge helpers compare the level held from the last clock with the level
  // seen now; both strobes and the wake input share the falling-edge one, so the three
  // detectors cannot drift apart.
  // Falling or rising edge of a sampled active-low strobe
  function automatic logic fell(input logic prev, input logic cur);
    fell = prev & ~cur;
  endfunction : fell

  function automatic logic rose(input logic prev, input logic cur);
    rose = ~prev & cur;
  endfunction : rose

  assign enabled = (chan_mode == MODE_FIFO);

  // Next-state logic for the whole port; every value starts from a hold or an
  // idle default, so no path leaves a latch behind
  always_comb begin
    // Levels are sampled every clock for the edge helpers
    rd_d      = rd_strobe_n;
    wr_d      = wr_strobe_n;
    wake_in_d = send_now_wake_in;
    // Flag enables rise on the first clock after reset
    out_en_d  = 1'b1;
    // Bus byte and receive flag hold unless the read logic or the idle port moves them
    dout_d    = dout_q;
    rx_flag_d = rx_flag_q;
    // Transmit flag simply mirrors room, one clock late
    tx_flag_d = ~tx_room;
    // Pulses are low unless an edge raises them
    push_d    = '0;
    pop_d     = 1'b0;
    now_d     = 1'b0;
    wake_d    = 1'b0;
    if (!enabled) begin
      // Port idle: flags stay inactive so a host never transfers
      rx_flag_d = 1'b1;
      tx_flag_d = 1'b1;
    end else begin
      // Read falling edge latches head byte onto the bus
      if (fell(rd_q, rd_strobe_n)) begin
        dout_d = rx_head.data;
      end
      // Read rising edge: flag up unconditionally, buffer advances
      if (rose(rd_q, rd_strobe_n)) begin
        rx_flag_d = 1'b1;
        pop_d     = 1'b1;
      end else if (rd_q && rd_strobe_n && !pop_q) begin
        // Lowered only once the advanced head has had a cycle to settle;
        // lowering earlier could flag the byte that was just read
        rx_flag_d = ~rx_head.valid;
      end
      // Write falling edge captures the bus byte; no room means it is dropped
      if (fell(wr_q, wr_strobe_n) && tx_room) begin
        push_d.valid = 1'b1;
        push_d.data  = data_bus_in;
      end
      // Wake pin low pulse: resume when suspended, flush otherwise
      if (fell(wake_in_q, send_now_wake_in)) begin
        if (usb_state.suspended) begin
          // Without wake enabled a suspended port ignores the pulse
          wake_d = usb_state.wake_enabled;
        end else begin
          now_d = 1'b1;
        end
      end
    end
  end

  // Every register resets to its idle value: strobes high, flags high and all
  // pulses low, so no false edge and no stray pulse follows the release of
  // reset. The flag enables stay low until the first clock after release.
  // Register stage only
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_q      <= STROBE_IDLE;
      wr_q      <= STROBE_IDLE;
      wake_in_q <= STROBE_IDLE;
      out_en_q  <= 1'b0;
      dout_q    <= 8'h00;
      rx_flag_q <= 1'b1;
      tx_flag_q <= 1'b1;
      push_q   <= '0;
      pop_q    <= 1'b0;
      now_q    <= 1'b0;
      wake_q   <= 1'b0;
    end else begin
      rd_q      <= rd_d;
      wr_q      <= wr_d;
      wake_in_q <= wake_in_d;
      out_en_q  <= out_en_d;
      dout_q    <= dout_d;
      rx_flag_q <= rx_flag_d;
      tx_flag_q <= tx_flag_d;
      push_q   <= push_d;
      pop_q    <= pop_d;
      now_q    <= now_d;
      wake_q   <= wake_d;
    end
  end

  // Pin outputs; bus driven only while read strobe is low
  assign data_bus_out     = dout_q;
  assign data_bus_oe      = enabled & ~rd_strobe_n & ~rd_q;
  // Flags float during reset; external pull-up gives high
  assign rx_data_avail_oe = out_en_q & arst_n;
  assign tx_room_avail_oe = out_en_q & arst_n;
  // Flag levels come straight from flip-flops; the pull-up outside matters
  // only while the enables are low
  assign rx_data_avail_n  = rx_flag_q;
  assign tx_room_avail_n  = tx_flag_q;
  // Pulses to the USB engine are registered, one clock wide each
  assign rx_pop           = pop_q;
  assign tx_push          = push_q;
  assign send_now         = now_q;
  assign wake_req         = wake_q;

  // Assertions; each watches what the port drives, sampled on the rising edge

  // Bus is only driven while the read strobe is low
  chk_bus_drive_rd: assert property (@(posedge sys_clk) disable iff (!arst_n)
    data_bus_oe |-> !rd_strobe_n) else $error("bus driven with read high");
  // Flag goes high after every read
  chk_flag_rise: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (enabled && $rose(rd_strobe_n)) |=> rx_data_avail_n) else $error("rx flag not raised");
  // Every read rise advances the receive buffer
  chk_pop_edge: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (enabled && $rose(rd_strobe_n)) |=> rx_pop) else $error("no pop on read rise");
  // Advance is a single-clock pulse
  chk_pop_once: assert property (@(posedge sys_clk) disable iff (!arst_n)
    rx_pop |=> !rx_pop) else $error("pop longer than one cycle");
  // Read fall puts the head byte on the bus
  chk_head_byte: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (enabled && $fell(rd_strobe_n)) |=> data_bus_out == $past(rx_head.data)) else $error("wrong head byte");
  // Write fall with room captures the bus byte
  chk_wr_capture: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (enabled && $fell(wr_strobe_n) && tx_room) |=> tx_push.valid && tx_push.data == $past(data_bus_in))
    else $error("write byte not captured");
  // No push without a write falling edge
  chk_push_cause: assert property (@(posedge sys_clk) disable iff (!arst_n)
    tx_push.valid |-> $past(wr_q) && !$past(wr_strobe_n)) else $error("push without write edge");
  // Transmit flag mirrors room one clock late
  chk_tx_flag_room: assert property (@(posedge sys_clk) disable iff (!arst_n)
    enabled ##1 enabled |-> tx_room_avail_n == !$past(tx_room)) else $error("tx flag mismatch");
  // Resume only while suspended with wake enabled
  chk_wake_susp: assert property (@(posedge sys_clk) disable iff (!arst_n)
    wake_req |-> $past(usb_state.suspended) && $past(usb_state.wake_enabled)) else $error("bad wake");
  // Wake pulse in normal operation flushes
  chk_flush_run: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (enabled && $fell(send_now_wake_in) && !usb_state.suspended) |=> send_now) else $error("no flush");
  // Idle port shows both flags inactive
  chk_mode_off: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !enabled ##1 !enabled |-> rx_data_avail_n && tx_room_avail_n) else $error("flags active off mode");
  // Receive flag low only with a valid head
  chk_flag_valid: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !rx_data_avail_n |-> $past(rx_head.valid)) else $error("rx flag low without data");
  // Flags are released while reset holds
  chk_reset_float: assert property (@(posedge sys_clk)
    !arst_n |-> !rx_data_avail_oe && !tx_room_avail_oe) else $error("flags driven in reset");
  // Flags are driven once reset has been released for a clock
  chk_flags_driven: assert property (@(posedge sys_clk) disable iff (!arst_n)
    $past(arst_n) |-> rx_data_avail_oe && tx_room_avail_oe) else $error("flags not driven");
  // Bus is driven through a held read low
  chk_bus_on_read: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (enabled && $past(arst_n) && !rd_strobe_n && !$past(rd_strobe_n)) |-> data_bus_oe)
    else $error("bus not driven during read");
  // Idle port never drives the bus
  chk_oe_mode: assert property (@(posedge sys_clk) disable iff (!arst_n)
    data_bus_oe |-> enabled) else $error("bus driven off mode");
  // Bus byte does not move during a held read
  chk_head_stable: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (enabled && !rd_strobe_n && !$fell(rd_strobe_n)) |=> $stable(data_bus_out)) else $error("bus byte moved");
  // Receive flag holds while the read strobe is low
  chk_flag_hold_rd: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (enabled && !rd_strobe_n) |=> $stable(rx_data_avail_n)) else $error("rx flag moved in read");
  // Advance only after a read rising edge
  chk_pop_cause: assert property (@(posedge sys_clk) disable iff (!arst_n)
    rx_pop |-> $past(rd_strobe_n) && !$past(rd_q)) else $error("pop without read rise");
  // Flag is high with the advance pulse and one clock after
  chk_pop_flag_hi: assert property (@(posedge sys_clk) disable iff (!arst_n)
    rx_pop |-> rx_data_avail_n) else $error("rx flag low at pop");
  chk_flag_after_pop: assert property (@(posedge sys_clk) disable iff (!arst_n)
    rx_pop |=> rx_data_avail_n) else $error("rx flag low after pop");
  // Push only when room was there and the port was enabled
  chk_push_room: assert property (@(posedge sys_clk) disable iff (!arst_n)
    tx_push.valid |-> $past(tx_room) && $past(enabled)) else $error("push without room");
  // Push is a single-clock pulse
  chk_push_pulse: assert property (@(posedge sys_clk) disable iff (!arst_n)
    tx_push.valid |=> !tx_push.valid) else $error("push longer than one cycle");
  // Idle port neither pushes nor advances
  chk_mode_no_push: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !enabled |=> !tx_push.valid) else $error("push off mode");
  chk_mode_no_pop: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !enabled |=> !rx_pop) else $error("pop off mode");
  // Resume request is one clock wide and follows a wake input fall
  chk_wake_pulse: assert property (@(posedge sys_clk) disable iff (!arst_n)
    wake_req |=> !wake_req) else $error("wake longer than one cycle");
  chk_wake_cause: assert property (@(posedge sys_clk) disable iff (!arst_n)
    wake_req |-> $past(wake_in_q) && !$past(send_now_wake_in)) else $error("wake without pulse");
  // Resume and flush never come together
  chk_wake_apart: assert property (@(posedge sys_clk) disable iff (!arst_n)
    wake_req |-> !send_now) else $error("wake with flush");
  // Flush is one clock wide and only when not suspended
  chk_flush_pulse: assert property (@(posedge sys_clk) disable iff (!arst_n)
    send_now |=> !send_now) else $error("flush longer than one cycle");
  chk_flush_cause: assert property (@(posedge sys_clk) disable iff (!arst_n)
    send_now |-> $past(enabled) && !$past(usb_state.suspended)) else $error("flush while suspended");
endmodule : abfp_port
`default_nettype wire

// [dv/abfp_host_model.sv]
// Purpose: Host logic model that drives the strobes and the data bus
// Assumes: The host changes its strobes just after the falling clock edge
// Notes:   A released bus shows the inverse of its last level, not a held value
`timescale 1ns/1ns
`default_nettype none
module abfp_host_model (
  input  wire logic       sys_clk,  // System clock
  input  wire logic [7:0] dev_dout, // Device drive value
  input  wire logic       dev_oe,   // Device drive enable
  input  wire logic       rx_flag_n, // Receive flag pin
  input  wire logic       tx_flag_n, // Transmit flag pin
  output logic            rd_n,     // Read strobe
  output logic            wr_n,     // Write strobe
  output logic      [7:0] bus       // Resolved bus level
);
  logic [7:0] hd = 8'h00; // Host drive value
  logic       ho = 1'b0;  // Host drive enable
  logic [7:0] last = 8'h00; // Last driven level
  initial rd_n = 1'b1;
  initial wr_n = 1'b1;
  // Nobody drives: show the inverse so a stale byte never passes
  always_comb bus = dev_oe ? dev_dout : (ho ? hd : ~last);
  always @(posedge sys_clk) if (dev_oe | ho) last <= bus;
  // Bounded wait on the flag, then one read; strobes never overlap
  task automatic read_byte(output logic [7:0] d);
    int n;
    n = 0;
    while (rx_flag_n !== 1'b0 && n < 20) begin @(negedge sys_clk); n++; end
    @(negedge sys_clk) rd_n = 1'b0;
    repeat (3) @(negedge sys_clk);
    d = bus;
    rd_n = 1'b1;
    repeat (4) @(negedge sys_clk);
  endtask : read_byte
  // Data is valid at the falling strobe; gives up waiting after 20 cycles
  task automatic write_byte(input logic [7:0] d);
    int n;
    n = 0;
    while (tx_flag_n !== 1'b0 && n < 20) begin @(negedge sys_clk); n++; end
    @(negedge sys_clk);
    hd = d;
    ho = 1'b1;
    wr_n = 1'b0;
    repeat (2) @(negedge sys_clk);
    wr_n = 1'b1;
    ho = 1'b0;
    repeat (2) @(negedge sys_clk);
  endtask : write_byte
endmodule : abfp_host_model
`default_nettype wire

// [dv/abfp_port_tb.sv]
// Purpose: Self-checking bench for one byte FIFO host port channel
// Assumes: Inputs change at the falling clock edge
// Notes:   Pulses are counted so each test judges them afterwards
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin errors++; $display("BAD t=%0t %h %h", $time, a, b); end end
module abfp_port_tb;
  import abfp_pkg::*;
  logic            sys_clk = 1'b0;
  logic            arst_n = 1'b0;
  logic [1:0]      chan_mode = MODE_FIFO;
  abfp_usb_state_t usb_state = '0;
  logic            wake_in = 1'b1;
  abfp_byte_t      rx_head = '0;
  logic            tx_room = 1'b0;
  logic            rd_n, wr_n, oe, rx_flag, rx_flag_oe, tx_flag, tx_flag_oe, pop, sn, wk, rx_flag_at_pop;
  logic [7:0]      dout, bus, rdat, push_d;
  abfp_byte_t      push;
  int              errors = 0, n_compared = 0, n_pop = 0, n_push = 0, n_wk = 0, n_sn = 0;
  // Released flags float high through the pull-up
  wire logic       rx_flag_pin = rx_flag_oe ? rx_flag : 1'b1;
  wire logic       tx_flag_pin = tx_flag_oe ? tx_flag : 1'b1;
  always #5 sys_clk = ~sys_clk;
  abfp_port dut_u (.sys_clk(sys_clk), .arst_n(arst_n), .chan_mode(chan_mode), .usb_state(usb_state),
    .rd_strobe_n(rd_n), .wr_strobe_n(wr_n), .send_now_wake_in(wake_in), .data_bus_in(bus),
    .data_bus_out(dout), .data_bus_oe(oe), .rx_data_avail_n(rx_flag), .rx_data_avail_oe(rx_flag_oe),
    .tx_room_avail_n(tx_flag), .tx_room_avail_oe(tx_flag_oe), .rx_head(rx_head), .rx_pop(pop),
    .tx_push(push), .tx_room(tx_room), .send_now(sn), .wake_req(wk));
  abfp_host_model host_u (.sys_clk(sys_clk), .dev_dout(dout), .dev_oe(oe), .rx_flag_n(rx_flag_pin),
    .tx_flag_n(tx_flag_pin), .rd_n(rd_n), .wr_n(wr_n), .bus(bus));
  // Count one-cycle pulses at the falling edge, where registered outputs have settled
  always @(negedge sys_clk) begin
    if (pop === 1'b1) begin n_pop++; rx_flag_at_pop = rx_flag_pin; end
    if (push.valid === 1'b1) begin n_push++; push_d = push.data; end
    if (wk === 1'b1) n_wk++;
    if (sn === 1'b1) n_sn++;
  end
  task automatic pulse_wake;
    @(negedge sys_clk) wake_in = 1'b0;
    repeat (2) @(negedge sys_clk);
    wake_in = 1'b1;
    repeat (3) @(negedge sys_clk);
  endtask : pulse_wake
  task automatic t_read;
    rx_head = '{1'b1, 8'ha5};
    repeat (3) @(negedge sys_clk);
    `CHK(rx_flag_pin, 1'b0)
    host_u.read_byte(rdat);
    `CHK(rdat, 8'ha5)
    `CHK(oe, 1'b0)
    `CHK(n_pop, 1)
    `CHK(rx_flag_at_pop, 1'b1)
    rx_head = '{1'b1, 8'h5a};
    host_u.read_byte(rdat);
    `CHK(rdat, 8'h5a)
    rx_head = '0;
    repeat (4) @(negedge sys_clk);
    `CHK(rx_flag_pin, 1'b1)
    $display("done read");
  endtask : t_read
  task automatic t_write;
    tx_room = 1'b1;
    repeat (3) @(negedge sys_clk);
    `CHK(tx_flag_pin, 1'b0)
    host_u.write_byte(8'h3c);
    `CHK(n_push, 1)
    `CHK(push_d, 8'h3c)
    tx_room = 1'b0;
    host_u.write_byte(8'hc3);
    `CHK(tx_flag_pin, 1'b1)
    `CHK(n_push, 1)
    $display("done write");
  endtask : t_write
  task automatic t_wake;
    usb_state = '{1'b1, 1'b1};
    pulse_wake();
    `CHK(n_wk, 1)
    `CHK(n_sn, 0)
    usb_state = '0;
    pulse_wake();
    `CHK(n_sn, 1)
    $display("done wake");
  endtask : t_wake
  task automatic t_mode;
    chan_mode = MODE_OFF;
    tx_room = 1'b1;
    rx_head = '{1'b1, 8'h11};
    host_u.write_byte(8'h77);
    `CHK(rx_flag_pin, 1'b1)
    `CHK(n_push, 1)
    $display("done mode");
  endtask : t_mode
  task automatic print_verdict;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (20) @(negedge sys_clk);
    `CHK(rx_flag_oe, 1'b0)
    `CHK(tx_flag_pin, 1'b1)
    arst_n = 1'b1;
    repeat (2) @(negedge sys_clk);
    t_read();
    t_write();
    t_wake();
    t_mode();
    print_verdict();
  end
  // Whole run needs about a hundred cycles
  initial begin
    #100000;
    errors++;
    print_verdict();
  end
endmodule : abfp_port_tb
`default_nettype wire
